// [design/pcs_ctrl_pkg.sv]
// constants for bits 15 down to 5 of the pcs management control register
// Contract
// - isolate bit set cuts pcs logic off the gmii; resets to one
// - writing one to restart bit restarts negotiation, then self-clears; reset zero
// - duplex bit always reads one, writes ignored
// - collision test bit always reads zero, writes ignored
// - 1000base-x/2500base-x: speed msb always reads one
// - sgmii speed pair encodes rate; writable only in controller mode
// - unidirectional enable allows transmit without link, only when negotiation off
// - bits four down to zero read zero, writes discarded
// - negotiation enable bit turns negotiation on or off; defaults to one
// - 1000base-x/2500base-x: speed lsb always reads zero
package pcs_ctrl_pkg;
  localparam int unsigned REG_W      = 16;
  localparam int unsigned BIT_RESET  = 15;
  localparam int unsigned BIT_LOOP   = 14;
  localparam int unsigned BIT_SPD_LS = 13;
  localparam int unsigned BIT_AN_EN  = 12;
  localparam int unsigned BIT_PWRDN  = 11;
  localparam int unsigned BIT_ISO    = 10;
  localparam int unsigned BIT_AN_RST = 9;
  localparam int unsigned BIT_DUPLEX = 8;
  localparam int unsigned BIT_COLTST = 7;
  localparam int unsigned BIT_SPD_MS = 6;
  localparam int unsigned BIT_UNIDIR = 5;

  localparam logic       RST_ISO    = 1'b1;
  localparam logic       RST_AN_EN  = 1'b1;
  localparam logic       RST_UNIDIR = 1'b0;
  localparam logic       RST_AN_RST = 1'b0;
  localparam logic [1:0] SPD_1G     = 2'h2;
  localparam logic       FIX_DUPLEX = 1'b1;
  localparam logic       FIX_COLTST = 1'b0;
  localparam logic [REG_W-1:0] ZERO_WORD = 16'h0000;
endpackage

// [design/restart_pulse.sv]
// self-clearing negotiation restart bit
module restart_pulse (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  // request
  input  wire logic i_req,
  // registered pulse to the pcs; the readback of the bit is registered in the parent
  output logic      o_pulse
);
  logic pulse_d;
  logic pulse_q;

  always_comb begin
    pulse_d = i_req;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_q <= pcs_ctrl_pkg::RST_AN_RST;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  assign o_pulse = pulse_q;
endmodule

// [design/pcs_control_reg_low_bits.sv]
// pcs management control register, bits 13 down to 5 plus fixed readbacks
module pcs_control_reg_low_bits #(
  parameter bit AN_BUILT_IN = 1'b1
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // management access (mdio or configuration vector)
  input  wire logic        i_reg_wr,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  // readback of bits 15, 14, 11 held elsewhere
  input  wire logic [2:0]  i_hi_rd,
  // operating mode
  input  wire logic        i_sgmii_mode,
  input  wire logic        i_ctrl_mode,
  // controls to the pcs
  output logic             o_isolate,
  output logic             o_an_enable,
  output logic             o_an_restart,
  output logic [1:0]       o_speed,
  output logic             o_unidir_tx
);

  ////////////////////////////////////////////////////////////////////////////
  logic       iso_d,   iso_q;
  logic       anen_d,  anen_q;
  logic       unid_d,  unid_q;
  logic [1:0] spd_d,   spd_q;
  logic       utx_d,   utx_q;
  logic [15:0] rd_d,   rd_q;
  logic       restart_req;
  logic       restart_q;
  logic       spd_wr_ok;

  // speed pair only writable in sgmii controller mode
  assign spd_wr_ok = i_sgmii_mode & i_ctrl_mode;

  always_comb begin
    iso_d  = iso_q;
    anen_d = anen_q;
    unid_d = unid_q;
    spd_d  = spd_wr_ok ? spd_q : pcs_ctrl_pkg::SPD_1G;
    restart_req = 1'b0;
    if (i_reg_wr) begin
      iso_d  = i_reg_wdata[pcs_ctrl_pkg::BIT_ISO];
      anen_d = AN_BUILT_IN & i_reg_wdata[pcs_ctrl_pkg::BIT_AN_EN];
      unid_d = i_reg_wdata[pcs_ctrl_pkg::BIT_UNIDIR];
      restart_req = AN_BUILT_IN & i_reg_wdata[pcs_ctrl_pkg::BIT_AN_RST];
      if (spd_wr_ok) begin
        spd_d = {i_reg_wdata[pcs_ctrl_pkg::BIT_SPD_MS],
                 i_reg_wdata[pcs_ctrl_pkg::BIT_SPD_LS]};
      end
    end
    // transmit without link only when negotiation is off
    utx_d = unid_d & ~anen_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback built from next values so a read after a write sees it
  always_comb begin
    rd_d = pcs_ctrl_pkg::ZERO_WORD;
    rd_d[pcs_ctrl_pkg::BIT_RESET]  = i_hi_rd[2];
    rd_d[pcs_ctrl_pkg::BIT_LOOP]   = i_hi_rd[1];
    rd_d[pcs_ctrl_pkg::BIT_PWRDN]  = i_hi_rd[0];
    rd_d[pcs_ctrl_pkg::BIT_SPD_LS] = spd_d[0];
    rd_d[pcs_ctrl_pkg::BIT_AN_EN]  = anen_d;
    rd_d[pcs_ctrl_pkg::BIT_ISO]    = iso_d;
    rd_d[pcs_ctrl_pkg::BIT_AN_RST] = restart_req;
    rd_d[pcs_ctrl_pkg::BIT_DUPLEX] = pcs_ctrl_pkg::FIX_DUPLEX;
    rd_d[pcs_ctrl_pkg::BIT_COLTST] = pcs_ctrl_pkg::FIX_COLTST;
    rd_d[pcs_ctrl_pkg::BIT_SPD_MS] = spd_d[1];
    rd_d[pcs_ctrl_pkg::BIT_UNIDIR] = unid_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      iso_q  <= pcs_ctrl_pkg::RST_ISO;
      anen_q <= AN_BUILT_IN ? pcs_ctrl_pkg::RST_AN_EN : 1'b0;
      unid_q <= pcs_ctrl_pkg::RST_UNIDIR;
      spd_q  <= pcs_ctrl_pkg::SPD_1G;
      utx_q  <= 1'b0;
      rd_q   <= pcs_ctrl_pkg::ZERO_WORD;
    end else begin
      iso_q  <= iso_d;
      anen_q <= anen_d;
      unid_q <= unid_d;
      spd_q  <= spd_d;
      utx_q  <= utx_d;
      rd_q   <= rd_d;
    end
  end

  restart_pulse u_restart (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_req     (restart_req),
    .o_pulse   (restart_q)
  );

  assign o_isolate    = iso_q;
  assign o_an_enable  = anen_q;
  assign o_an_restart = restart_q;
  assign o_speed      = spd_q;
  assign o_unidir_tx  = utx_q;
  assign o_reg_rdata  = rd_q;
endmodule

// [verif/pcs_ctrl_checker.sv]
// assertions on the low control register bits
module pcs_ctrl_checker (
  input wire logic        i_clk_sys, i_rst_n, i_reg_wr, i_sgmii_mode, i_ctrl_mode,
  input wire logic [15:0] i_reg_wdata, o_reg_rdata,
  input wire logic        o_isolate, o_an_enable, o_an_restart, o_unidir_tx,
  input wire logic [1:0]  o_speed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // readback lags release by one edge, hence the past reset term
  a_iso_write: assert property (i_reg_wr |=> o_isolate == $past(i_reg_wdata[10]))
    else $error("isolate not taken");
  a_restart_pulse: assert property (o_an_restart == $past(i_reg_wr & i_reg_wdata[9]))
    else $error("restart pulse wrong");
  a_duplex_one: assert property ($past(i_rst_n) |-> o_reg_rdata[8])
    else $error("duplex bit low");
  a_col_zero: assert property ($past(i_rst_n) |-> !o_reg_rdata[7])
    else $error("collision bit high");
  a_rsvd_zero: assert property ($past(i_rst_n) |-> o_reg_rdata[4:0] == 5'h0)
    else $error("reserved bits set");
  a_speed_fixed: assert property (!(i_sgmii_mode && i_ctrl_mode) |=> o_speed == 2'h2)
    else $error("speed not fixed");
  a_speed_sgmii: assert property (i_reg_wr && i_sgmii_mode && i_ctrl_mode |=>
    o_speed == {$past(i_reg_wdata[6]), $past(i_reg_wdata[13])}) else $error("speed not taken");
  a_unidir_gate: assert property (i_reg_wr |=>
    o_unidir_tx == ($past(i_reg_wdata[5]) && !$past(i_reg_wdata[12]))) else $error("unidir");
  a_an_enable: assert property (i_reg_wr |=> o_an_enable == $past(i_reg_wdata[12]))
    else $error("an enable not taken");
  c_restart: cover property (o_an_restart);
  c_sgmii_wr: cover property (i_reg_wr && i_sgmii_mode && i_ctrl_mode);
  c_unidir: cover property (o_unidir_tx);
endmodule

// [verif/mgmt_station.sv]
// station manager model: read-modify-write of the control word
module mgmt_station (
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_rdata,
  output logic             o_wr,
  output logic      [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_wr = 1'b0;
  initial o_wdata = 16'h0000;
  // untouched fields go back as read, so no stray control action
  task automatic rmw(input logic [15:0] mask, input logic [15:0] val);
    @(negedge i_clk_sys);
    o_wdata = (i_rdata & ~mask) | (val & mask);
    o_wr = 1'b1;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_wdata = ~o_wdata;
  endtask
endmodule

// [verif/tb_pcs_control_reg_low_bits.sv]
// testbench for the low control register bits
module tb_pcs_control_reg_low_bits;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk_sys, i_rst_n, i_reg_wr, i_sgmii_mode, i_ctrl_mode;
  logic        o_isolate, o_an_enable, o_an_restart, o_unidir_tx;
  logic [15:0] i_reg_wdata, o_reg_rdata;
  logic [2:0]  i_hi_rd;
  logic [1:0]  o_speed;
  int          err_count = 0;
  int          check_count = 0;
  pcs_control_reg_low_bits uut (.i_clk_sys, .i_rst_n, .i_reg_wr, .i_reg_wdata, .o_reg_rdata,
    .i_hi_rd, .i_sgmii_mode, .i_ctrl_mode, .o_isolate, .o_an_enable, .o_an_restart,
    .o_speed, .o_unidir_tx);
  mgmt_station st (.i_clk_sys, .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_wdata(i_reg_wdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // also used after the last scenario, so state left by earlier scenarios must clear
  task automatic t_reset(input int n);
    i_rst_n = 1'b0;
    repeat (n) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    @(negedge i_clk_sys);
    chk(o_reg_rdata, 16'h9d40);
    chk({o_isolate, o_an_enable, o_an_restart, o_speed, o_unidir_tx}, 16'h0034);
  endtask
  task automatic t_fixed;
    st.rmw(16'hffff, 16'hffff);
    chk(o_reg_rdata, 16'h9f60);
    chk({o_unidir_tx, o_an_restart}, 16'h0001);
    @(negedge i_clk_sys);
    chk(o_reg_rdata, 16'h9d60);
    chk(o_an_restart, 16'h0000);
  endtask
  task automatic t_unidir;
    st.rmw(16'h1020, 16'h0020);
    chk({o_unidir_tx, o_isolate, o_an_enable}, 16'h0006);
    st.rmw(16'h0400, 16'h0000);
    chk({o_isolate, o_unidir_tx}, 16'h0001);
  endtask
  task automatic t_sgmii;
    i_sgmii_mode = 1'b1;
    i_ctrl_mode = 1'b1;
    for (int c = 0; c < 4; c++) begin
      st.rmw(16'h2040, {2'h0, c[0], 6'h00, c[1], 6'h00});
      chk(o_speed, 16'(c));
      chk({o_reg_rdata[6], o_reg_rdata[13]}, 16'(c));
    end
    i_ctrl_mode = 1'b0;
    @(negedge i_clk_sys);
    chk(o_speed, 16'h0002);
    i_sgmii_mode = 1'b0;
    i_ctrl_mode = 1'b1;
    st.rmw(16'h2040, 16'h0000);
    chk(o_speed, 16'h0002);
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    i_hi_rd = 3'h5;
    i_sgmii_mode = 1'b0;
    i_ctrl_mode = 1'b0;
    t_reset(16);
    t_fixed;
    t_unidir;
    t_sgmii;
    t_reset(2);
    results;
  end
endmodule
bind pcs_control_reg_low_bits pcs_ctrl_checker chk_i (.i_clk_sys, .i_rst_n, .i_reg_wr,
  .i_sgmii_mode, .i_ctrl_mode, .i_reg_wdata, .o_reg_rdata, .o_isolate, .o_an_enable,
  .o_an_restart, .o_unidir_tx, .o_speed);
